// ===== src/gnss_sample_serializer_config.sv
// Notes on behaviour
// [RULE_01] Two-channel output: MSB on each upper pin, LSB on each lower pin.
// [RULE_02] Three-bit I-only: MSB on I upper, middle on I lower, LSB on Q upper.
// [RULE_03] Width defaults to two; one or two with I/Q, up to three I-only.
// [RULE_04] Format field picks unsigned, sign/magnitude or two's complement coding.
// [RULE_05] Twelve-bit fractional divider: ratio is low over 4096 minus high plus low.
// [RULE_06] Divider alternates adjacent integer periods to reach the fractional mean.
// [RULE_07] Two-bit I/Q: bits 0..3 are I sign, I magnitude, Q sign, Q magnitude.
// [RULE_08] Stream sends 16-bit segments per bit in order 0,1,2,3, skipping unselected.
// [RULE_09] Lane select field: bit 0; bits 0,1; bits 0,2; or all four.
// [RULE_10] Two lanes alternate 16 bits each; one lane carries bit 0 alone.
// [RULE_11] Stream clock must be twice or four times the sample clock, per lanes.
// [RULE_12] Four 16-bit holding registers capture samples on the sample clock.
// [RULE_13] Every 16 samples holding data moves to shift registers for streaming.
// [RULE_14] After all valid slice data the serial output stays zero.
// [RULE_15] Slice-start strobe marks the beginning of every valid 16-bit slice.
// [RULE_16] Time-mark strobe repeats every 128 to 16384 sample clocks.
// [RULE_17] Preset pin high: clock, data, select levels index one of eight presets.
// [RULE_18] Reset loads the register defaults.
// [RULE_19] A 32-bit word shifts in while select is low, D27 first.
// [RULE_20] Four-bit address selects one of ten registers, codes 0 through 9.
// [RULE_21] Stream control register holds the number of frames to send.
// [RULE_22] Divider low and high counts live in the register at address 7.
// [RULE_23] Word is 28 data bits then 4 address bits, sampled on clock rise.
// [RULE_24] Select rising after a full word writes data to the addressed register.
`timescale 1ns/1ps
`default_nettype none
module gnss_sample_serializer_config (
  input  wire logic                ref_clk,              // 100 MHz reference clock
  input  wire logic                rst,                  // Synchronous reset, active high
  input  wire logic                preset_select_pin,    // High selects preset states
  input  wire logic                config_serial_clk,    // Config port clock pin
  input  wire logic                config_serial_data,   // Config port data pin
  input  wire logic                config_select_n,      // Config port select, active low
  input  wire logic                stream_serial_clk,    // Stream clock from the DSP
  input  wire logic [2:0]          adc_i_raw,            // I converter code
  input  wire logic [2:0]          adc_q_raw,            // Q converter code
  output logic                     inphase_high_pin,     // I channel upper pin
  output logic                     inphase_low_pin,      // I channel lower pin
  output logic                     quadrature_high_pin,  // Q channel upper pin
  output logic                     quadrature_low_pin,   // Q channel lower pin
  output logic                     stream_serial_data,   // Serialized sample data
  output logic                     slice_start_strobe,   // High for first bit of a slice
  output logic                     time_mark_strobe,     // One-cycle periodic mark
  output logic                     sample_clk_tick,      // Sample clock enable pulse
  output logic [9:0][27:0]         config_words          // All registers, for the chip
);
  // Synchroniser lane indices
  localparam int S_SCLK   = 0;
  localparam int S_CONFIG_SERIAL_DATA  = 1;
  localparam int S_SEL    = 2;
  localparam int S_PRESET = 3;
  localparam int S_STREAM_CONTROL   = 4;

  typedef enum logic {CFG_IDLE, CFG_SHIFT} cfg_state_type;

  typedef struct packed {
    logic [4:0]                  meta;
    logic [4:0]                  sync;
    logic [4:0]                  prev;
    cfg_state_type               cfg_st;
    logic [5:0]                  bit_cnt;
    logic [31:0]                 shift;
    logic [9:0][27:0]            regs;
    logic [3:0]                  smp_cnt;
    logic [3:0][15:0]            hold;
    logic [3:0][15:0]            shreg;
    logic [1:0]                  lane;
    logic [3:0]                  seg_cnt;
    logic                        active;
    logic [19:0]                 frames;
    logic [14:0]                 tm_cnt;
    gnss_cfg_pkg::pins_type      pins;
    gnss_cfg_pkg::stream_out_type so;
  } state_type;

  state_type              s;
  state_type              n;
  logic                   tick;
  logic [3:0]             fbits;
  gnss_cfg_pkg::pins_type fpins;
  logic                   sclk_rise;
  logic                   stream_control_rise;
  logic [2:0]             preset_idx;
  logic [3:0]             lane_mask;
  logic [19:0]            frame_limit;
  logic [14:0]            tm_period;
  logic                   load_ok;
  logic [3:0]             word_addr;
  logic [27:0]            word_data;
  logic                   commit;

  // Edges come from the second and third stages only
  assign sclk_rise  = s.sync[S_SCLK] & ~s.prev[S_SCLK];
  assign stream_control_rise  = s.sync[S_STREAM_CONTROL] & ~s.prev[S_STREAM_CONTROL];
  // Clock is the MSB of the preset index, select the LSB
  assign preset_idx = {s.sync[S_SCLK], s.sync[S_CONFIG_SERIAL_DATA], s.sync[S_SEL]};  // [RULE_17]
  assign word_addr  = s.shift[3:0];   // [RULE_23]
  assign word_data  = s.shift[31:4];  // [RULE_23]
  assign commit     = (s.cfg_st == CFG_SHIFT) & s.sync[S_SEL]
                    & (s.bit_cnt == gnss_cfg_pkg::WORD_BITS) & ~s.sync[S_PRESET];

  // Stream configuration fields
  assign lane_mask   = gnss_cfg_pkg::LANE_MASKS[
    s.regs[gnss_cfg_pkg::ADDR_SUPPORT][gnss_cfg_pkg::LANE_SEL_LSB +: 2]];  // [RULE_09]
  assign frame_limit = s.regs[gnss_cfg_pkg::ADDR_STREAM][gnss_cfg_pkg::FRAMES_LSB +:
                                                        gnss_cfg_pkg::FRAMES_W];  // [RULE_21]
  // Period is the base shifted by a 3-bit exponent, spanning 128 to 16384
  assign tm_period   = gnss_cfg_pkg::TMARK_BASE <<
                       s.regs[gnss_cfg_pkg::ADDR_STREAM][gnss_cfg_pkg::TMARK_LSB +: 3];  // [RULE_16]
  assign load_ok     = s.regs[gnss_cfg_pkg::ADDR_STREAM][gnss_cfg_pkg::STREAM_EN_BIT]
                     & ((frame_limit == '0) | (s.frames < frame_limit));  // [RULE_21]

  frac_clock_divider #(
    .CNT_W (gnss_cfg_pkg::DIV_W)
  ) u_divider (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .low_cnt  (s.regs[gnss_cfg_pkg::ADDR_SAMPLE_DIV][gnss_cfg_pkg::DIV_L_LSB +: 12]),  // [RULE_22]
    .high_cnt (s.regs[gnss_cfg_pkg::ADDR_SAMPLE_DIV][gnss_cfg_pkg::DIV_M_LSB +: 12]),  // [RULE_22]
    .tick     (tick)
  );

  sample_formatter u_formatter (
    .i_raw (adc_i_raw),
    .q_raw (adc_q_raw),
    .fmt   (s.regs[gnss_cfg_pkg::ADDR_GAIN_OUT][gnss_cfg_pkg::FMT_LSB +: 2]),      // [RULE_04]
    .width (s.regs[gnss_cfg_pkg::ADDR_GAIN_OUT][gnss_cfg_pkg::WIDTH_LSB +: 3]),    // [RULE_03]
    .iq_en (s.regs[gnss_cfg_pkg::ADDR_GAIN_OUT][gnss_cfg_pkg::IQ_EN_BIT]),
    .lbits (fbits),
    .pins  (fpins)
  );

  // Next lane above the current one that the mask selects, or the current if none
  function automatic logic [1:0] next_lane(input logic [1:0] cur, input logic [3:0] mask);
    logic [1:0] nl;
    nl = cur;
    for (int k = gnss_cfg_pkg::LANES - 1; k > 0; k--) begin
      if (mask[k] && (k > int'(cur))) nl = 2'(k);
    end
    next_lane = nl;
  endfunction

  // Next-state logic for the whole block
  always_comb begin
    n                = s;
    n.meta           = {stream_serial_clk, preset_select_pin, config_select_n,
                        config_serial_data, config_serial_clk};
    n.sync           = s.meta;
    n.prev           = s.sync;
    n.so.time_mark   = 1'b0;

    // Preset pin overrides serial programming while it stays high
    if (s.sync[S_PRESET]) begin
      n.regs             = gnss_cfg_pkg::POR_VALUES;
      n.regs[0]          = gnss_cfg_pkg::PRESET_RX_IF[preset_idx];     // [RULE_17]
      n.regs[gnss_cfg_pkg::ADDR_GAIN_OUT] = gnss_cfg_pkg::PRESET_GAIN_OUT[preset_idx];
      n.regs[gnss_cfg_pkg::ADDR_DIVIDER]  = gnss_cfg_pkg::PRESET_DIVIDER[preset_idx];
      n.regs[gnss_cfg_pkg::ADDR_TEST_MODE_SECOND]    = gnss_cfg_pkg::PRESET_TEST_MODE_SECOND[preset_idx];
      n.cfg_st           = CFG_IDLE;
    end else begin
      case (s.cfg_st)
        CFG_IDLE: begin
          if (!s.sync[S_SEL]) begin
            n.cfg_st  = CFG_SHIFT;
            n.bit_cnt = '0;
          end
        end
        CFG_SHIFT: begin
          // Extra clocks past 32 still shift in and push the count past 32, which spoils the word
          if (sclk_rise && !s.sync[S_SEL]) begin
            n.shift = {s.shift[30:0], s.sync[S_CONFIG_SERIAL_DATA]};  // [RULE_19]
            if (s.bit_cnt <= gnss_cfg_pkg::WORD_BITS) n.bit_cnt = s.bit_cnt + 6'h01;
          end
          if (s.sync[S_SEL]) begin
            n.cfg_st = CFG_IDLE;
            if (commit && (word_addr <= gnss_cfg_pkg::ADDR_LAST)) begin  // [RULE_20]
              n.regs[word_addr] = word_data;  // [RULE_24]
              if (word_addr == gnss_cfg_pkg::ADDR_STREAM) n.frames = '0;
            end
          end
        end
        default: n.cfg_st = CFG_IDLE;
      endcase
    end

    // Stream side: one bit per rising stream clock, zeros once the slice is out
    if (stream_control_rise) begin
      if (s.active) begin
        n.so.data        = s.shreg[s.lane][gnss_cfg_pkg::SLICE_LAST - s.seg_cnt];  // [RULE_08]
        n.so.slice_start = (s.seg_cnt == '0);                                      // [RULE_15]
        n.seg_cnt        = s.seg_cnt + 4'h1;
        if (s.seg_cnt == gnss_cfg_pkg::SLICE_LAST) begin
          if (next_lane(s.lane, lane_mask) == s.lane) n.active = 1'b0;  // [RULE_10]
          else n.lane = next_lane(s.lane, lane_mask);                    // [RULE_09]
        end
      end else begin
        n.so.data        = 1'b0;  // [RULE_14]
        n.so.slice_start = 1'b0;
      end
    end

    // Sample side: capture, time mark and block transfer on each sample clock
    if (tick) begin
      n.pins    = fpins;  // [RULE_01]
      n.smp_cnt = s.smp_cnt + 4'h1;
      for (int b = 0; b < gnss_cfg_pkg::LANES; b++) begin
        n.hold[b] = {s.hold[b][14:0], fbits[b]};  // [RULE_12]
      end
      if (s.tm_cnt >= tm_period - 15'h0001) begin
        n.tm_cnt       = '0;
        n.so.time_mark = 1'b1;  // [RULE_16]
      end else begin
        n.tm_cnt       = s.tm_cnt + 15'h0001;
      end
      // A transfer restarts streaming; an unfinished slice is lost if the clock is slow
      if ((s.smp_cnt == gnss_cfg_pkg::SLICE_LAST) && load_ok) begin
        n.shreg   = n.hold;  // [RULE_13]
        n.active  = 1'b1;
        n.lane    = '0;
        n.seg_cnt = '0;
        n.frames  = s.frames + 20'h00001;
      end
    end
  end

  // Reset loads the power-on register contents
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s      <= '0;
      s.regs <= gnss_cfg_pkg::POR_VALUES;  // [RULE_18]
      s.sync <= 5'h04;
      s.meta <= 5'h04;
      s.prev <= 5'h04;
    end else begin
      s      <= n;
    end
  end

  // Outputs straight from state flip-flops
  assign inphase_high_pin    = s.pins.i_high;
  assign inphase_low_pin     = s.pins.i_low;
  assign quadrature_high_pin = s.pins.q_high;
  assign quadrature_low_pin  = s.pins.q_low;
  assign stream_serial_data  = s.so.data;
  assign slice_start_strobe  = s.so.slice_start;
  assign time_mark_strobe    = s.so.time_mark;
  assign sample_clk_tick     = tick;
  assign config_words        = s.regs;

  pin_update_a: assert property (@(posedge ref_clk) disable iff (rst)  // [RULE_01]
    tick |=> (inphase_high_pin == $past(fbits[0])) && (quadrature_low_pin == $past(fbits[3])))
    else $error("parallel pins do not follow the sample");

  three_bit_map_a: assert property (@(posedge ref_clk) disable iff (rst)  // [RULE_02]
    (tick && !s.regs[gnss_cfg_pkg::ADDR_GAIN_OUT][gnss_cfg_pkg::IQ_EN_BIT])
    |=> !quadrature_low_pin)
    else $error("Q lower pin driven in I-only mode");

  slice_mark_a: assert property (@(posedge ref_clk) disable iff (rst)  // [RULE_15]
    (stream_control_rise && s.active) |=> (slice_start_strobe == ($past(s.seg_cnt) == 4'h0)))
    else $error("slice start strobe misplaced");

  idle_zero_a: assert property (@(posedge ref_clk) disable iff (rst)  // [RULE_14]
    (stream_control_rise && !s.active) |=> !stream_serial_data && !slice_start_strobe)
    else $error("stream not zero after slice data");

  mark_period_a: assert property (@(posedge ref_clk) disable iff (rst)  // [RULE_16]
    time_mark_strobe |-> ($past(s.tm_cnt) >= $past(tm_period) - 15'h0001) && $past(tick))
    else $error("time mark at wrong count");

  block_load_a: assert property (@(posedge ref_clk) disable iff (rst)  // [RULE_13]
    (tick && (s.smp_cnt == 4'hf) && load_ok) |=> s.active && (s.lane == 2'h0)
    && (s.seg_cnt == 4'h0) && (s.shreg[0][0] == $past(fbits[0])))
    else $error("holding data not transferred");

  word_write_a: assert property (@(posedge ref_clk) disable iff (rst)  // [RULE_24]
    (commit && (word_addr <= 4'h9)) |=> (s.regs[$past(word_addr)] == $past(word_data)))
    else $error("configuration word not written");

  preset_load_a: assert property (@(posedge ref_clk) disable iff (rst)  // [RULE_17]
    s.sync[S_PRESET] |=> (s.regs[4] == gnss_cfg_pkg::PRESET_DIVIDER[$past(preset_idx)]))
    else $error("preset state not applied");

  lane_skip_a: assert property (@(posedge ref_clk) disable iff (rst)  // [RULE_09]
    (stream_control_rise && s.active && (s.seg_cnt == 4'hf) && (s.lane == 2'h0) && (lane_mask == 4'h5)
     && !(tick && (s.smp_cnt == 4'hf))) |=> (s.lane == 2'h2) && s.active)
    else $error("lane select did not skip bit 1");

  por_load_a: assert property (@(posedge ref_clk)  // [RULE_18]
    rst |=> (s.regs == gnss_cfg_pkg::POR_VALUES))
    else $error("reset did not load defaults");
endmodule  // gnss_sample_serializer_config
`default_nettype wire

// ===== include/gnss_cfg_pkg.sv
package gnss_cfg_pkg;
  // Register file geometry
  localparam int REG_COUNT = 10;
  localparam int DATA_W    = 28;
  localparam int WORD_W    = 32;
  localparam int LANES     = 4;
  localparam int SLICE_W   = 16;
  localparam int DIV_W     = 12;
  localparam logic [5:0] WORD_BITS  = 6'h20;
  localparam logic [3:0] SLICE_LAST = 4'hf;

  // Register addresses
  localparam logic [3:0] ADDR_GAIN_OUT   = 4'h1;
  localparam logic [3:0] ADDR_SUPPORT    = 4'h2;
  localparam logic [3:0] ADDR_DIVIDER    = 4'h4;
  localparam logic [3:0] ADDR_STREAM     = 4'h6;
  localparam logic [3:0] ADDR_SAMPLE_DIV = 4'h7;
  localparam logic [3:0] ADDR_TEST_MODE_SECOND      = 4'h9;
  localparam logic [3:0] ADDR_LAST       = 4'h9;

  // Power-on contents, index 0 is the last entry
  localparam logic [9:0][27:0] POR_VALUES = {
    28'h28c0402, 28'h1e0f401, 28'h10061b2, 28'h8000000, 28'h8000070,
    28'h0c00080, 28'h9ec0008, 28'heafe1dc, 28'h055028c, 28'ha2919a3};

  // Preset states 7 down to 0 for the registers that differ between presets
  localparam logic [7:0][27:0] PRESET_RX_IF = {
    28'ha29b26b, 28'ha293573, 28'ha293573, 28'ha2919a3,
    28'ha2919a3, 28'ha2919a7, 28'ha2919a3, 28'ha2919a3};
  localparam logic [7:0][27:0] PRESET_GAIN_OUT = {
    28'h855030c, 28'h855030c, 28'h855030c, 28'h055028c,
    28'h055028c, 28'h055121c, 28'h055028c, 28'h055121c};
  localparam logic [7:0][27:0] PRESET_DIVIDER = {
    28'h0bc80d0, 28'h0c00080, 28'h0ba00d0, 28'h3d62300,
    28'h0c00100, 28'h0c00080, 28'h0c00080, 28'h0c00080};
  localparam logic [7:0][27:0] PRESET_TEST_MODE_SECOND = {
    28'h7cc0403, 28'h28c0402, 28'h28c0402, 28'h28c0402,
    28'h28c0402, 28'h28c0402, 28'h28c0402, 28'h28c0402};

  // Field positions
  localparam int IQ_EN_BIT     = 27;
  localparam int FMT_LSB       = 9;
  localparam int WIDTH_LSB     = 6;
  localparam int LANE_SEL_LSB  = 4;
  localparam int STREAM_EN_BIT = 27;
  localparam int FRAMES_LSB    = 0;
  localparam int FRAMES_W      = 20;
  localparam int TMARK_LSB     = 20;
  localparam int DIV_L_LSB     = 16;
  localparam int DIV_M_LSB     = 4;

  // Number formats and widths
  localparam logic [1:0] FMT_UNSIGNED = 2'h0;
  localparam logic [1:0] FMT_SIGN_MAG = 2'h1;
  localparam logic [2:0] WIDTH_ONE    = 3'h1;
  localparam logic [2:0] WIDTH_THREE  = 3'h3;
  localparam logic [3:0][3:0] LANE_MASKS = {4'hf, 4'h5, 4'h3, 4'h1};

  // Divider modulus and time-mark base period
  localparam logic [13:0] DIV_MODULUS = 14'h1000;
  localparam logic [14:0] TMARK_BASE  = 15'h0080;

  typedef struct packed {
    logic i_high;
    logic i_low;
    logic q_high;
    logic q_low;
  } pins_type;

  typedef struct packed {
    logic data;
    logic slice_start;
    logic time_mark;
  } stream_out_type;
endpackage

// ===== src/sample_formatter.sv
`timescale 1ns/1ps
`default_nettype none
module sample_formatter (
  input  wire logic [2:0]          i_raw,    // I sample, sign then magnitude
  input  wire logic [2:0]          q_raw,    // Q sample, sign then magnitude
  input  wire logic [1:0]          fmt,      // Number format select
  input  wire logic [2:0]          width,    // Bits per sample
  input  wire logic                iq_en,    // Both channels when high
  output logic [3:0]               lbits,    // Logical stream bits 0..3
  output gnss_cfg_pkg::pins_type   pins      // Parallel pin values
);
  logic [2:0] i_code;
  logic [2:0] q_code;
  logic       w2;
  logic       w3;

  // Recode a sign/magnitude sample into the selected format
  function automatic logic [2:0] recode(input logic [2:0] raw, input logic [1:0] f);
    logic [1:0] mag;
    mag = raw[2] ? ~raw[1:0] : raw[1:0];
    case (f)
      gnss_cfg_pkg::FMT_UNSIGNED: recode = {~raw[2], mag};
      gnss_cfg_pkg::FMT_SIGN_MAG: recode = raw;
      default:                    recode = {raw[2], mag};
    endcase
  endfunction

  assign i_code = recode(i_raw, fmt);
  assign q_code = recode(q_raw, fmt);
  assign w2     = (width != gnss_cfg_pkg::WIDTH_ONE);
  // Three bits fit only when Q is off, so with both channels it is held to two
  assign w3     = (width == gnss_cfg_pkg::WIDTH_THREE) & ~iq_en;

  // Logical bit layout; truncation keeps the upper code bits
  assign lbits = iq_en ? {q_code[1] & w2, q_code[2], i_code[1] & w2, i_code[2]}  // [RULE_07]
                       : {1'b0, i_code[0] & w3, i_code[1] & w2, i_code[2]};      // [RULE_03]

  // Upper pin carries the MSB of each channel, lower pin the next bit
  assign pins.i_high = lbits[0];  // [RULE_01]
  assign pins.i_low  = lbits[1];  // [RULE_02]
  assign pins.q_high = lbits[2];  // [RULE_02]
  assign pins.q_low  = lbits[3];  // [RULE_01]
endmodule  // sample_formatter
`default_nettype wire

// ===== src/frac_clock_divider.sv
`timescale 1ns/1ps
`default_nettype none
module frac_clock_divider #(
  parameter int CNT_W = 12  // Width of both counts
) (
  input  wire logic             ref_clk,   // Reference clock
  input  wire logic             rst,       // Synchronous reset, active high
  input  wire logic [CNT_W-1:0] low_cnt,   // Low count
  input  wire logic [CNT_W-1:0] high_cnt,  // High count
  output logic                  tick       // One pulse per sample clock
);
  typedef struct packed {
    logic [CNT_W+1:0] acc;
    logic             tick;
  } state_type;

  state_type  s;
  state_type  n;
  logic [CNT_W+1:0] divisor;
  logic [CNT_W+1:0] sum;

  assign divisor = gnss_cfg_pkg::DIV_MODULUS - {2'h0, high_cnt} + {2'h0, low_cnt};  // [RULE_05]
  assign sum     = s.acc + {2'h0, low_cnt};

  // Accumulator overflow picks the long or short period so the mean is exact
  always_comb begin
    n      = s;
    n.tick = 1'b0;
    if (sum >= divisor) begin  // [RULE_06]
      n.acc  = sum - divisor;
      n.tick = 1'b1;
    end else begin
      n.acc  = sum;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) s <= '0;
    else     s <= n;
  end

  assign tick = s.tick;

  tick_on_wrap_a: assert property (@(posedge ref_clk) disable iff (rst)  // [RULE_06]
    (s.acc + {2'h0, low_cnt} >= divisor) |=> tick)
    else $error("divider missed a sample clock");
endmodule  // frac_clock_divider
`default_nettype wire

// ===== verif/stream_dsp_model.sv
`timescale 1ns/1ps
`default_nettype none
module stream_dsp_model (
  input  wire logic ref_clk,          // Reference clock
  input  wire logic rst,              // Synchronous reset
  input  wire logic run,              // Stream clock runs while high
  input  wire logic ser_data,         // Serial data from the device
  input  wire logic ser_start,        // Slice start from the device
  output var  logic ser_clk = 1'b0,   // Stream clock toward the device
  output logic      got,              // One pulse per captured bit
  output logic      got_data,         // Captured data bit
  output logic      got_start         // Captured slice start
);
  int unsigned phase;

  // Ten-cycle stream clock, over four times the slowed sample clock
  // Bits are taken just before each rise, when the previous bit has settled
  always @(posedge ref_clk) begin
    got <= 1'b0;
    if (rst || !run) begin
      phase   <= 0;
      ser_clk <= 1'b0; // Stands still while run is low or in reset
    end else begin
      phase <= (phase == 9) ? 0 : phase + 1;
      if (phase == 0) begin
        ser_clk   <= 1'b1;
        got       <= 1'b1;
        got_data  <= ser_data;
        got_start <= ser_start;
      end
      if (phase == 5) ser_clk <= 1'b0;
    end
  end
endmodule // stream_dsp_model
`default_nettype wire

// ===== verif/gnss_sample_serializer_config_bench.sv
`timescale 1ns/1ps
`default_nettype none
module gnss_sample_serializer_config_bench;
  logic ref_clk = 1'b0, rst = 1'b1, pre = 1'b0, sck = 1'b0, sdi = 1'b0, cs_n = 1'b1;
  logic run = 1'b0, cap = 1'b0, got, gd, gs, ssck, tick, tm, sd, ss, ih, il, qh, ql;
  logic [2:0] ai = 3'h0, aq = 3'h0;
  logic [9:0][27:0] cw;
  logic [1:0] cq[$];
  logic [31:0] seed = 32'h35e6;
  int n_fail = 0, n_tests = 0;

  always #5 ref_clk = ~ref_clk;

  gnss_sample_serializer_config i_gnss_sample_serializer_config (.ref_clk(ref_clk),
    .rst(rst), .preset_select_pin(pre), .config_serial_clk(sck), .config_serial_data(sdi),
    .config_select_n(cs_n), .stream_serial_clk(ssck), .adc_i_raw(ai), .adc_q_raw(aq),
    .inphase_high_pin(ih), .inphase_low_pin(il), .quadrature_high_pin(qh),
    .quadrature_low_pin(ql), .stream_serial_data(sd), .slice_start_strobe(ss),
    .time_mark_strobe(tm), .sample_clk_tick(tick), .config_words(cw));
  stream_dsp_model i_stream_dsp_model (.ref_clk(ref_clk), .rst(rst), .run(run),
    .ser_data(sd), .ser_start(ss), .ser_clk(ssck), .got(got), .got_data(gd), .got_start(gs));

  // Log every captured stream bit while a capture window is open
  always @(posedge ref_clk) if (cap && got) cq.push_back({gs, gd});

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Three-bit code of a sign/magnitude sample; narrower widths keep the top bits
  function automatic logic [2:0] code(input logic [2:0] r, input logic [1:0] f);
    logic [2:0] t;
    t = {r[2], r[2] ? ~r[1:0] : r[1:0]};
    if (f == gnss_cfg_pkg::FMT_SIGN_MAG) return r;
    if (f == gnss_cfg_pkg::FMT_UNSIGNED) return {~t[2], t[1:0]};
    return t;
  endfunction

  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic chk(input logic [27:0] g, input logic [27:0] e, input string m);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, g, e);
    end
  endtask
  task automatic chk_n(input int g, input int lo, input int hi, input string m);
    n_tests++;
    if (g < lo || g > hi) begin
      n_fail++;
      $display("CHECK FAILED t=%0t %s got %0d", $time, m, g);
    end
  endtask
  // Levels held four cycles each so the synchronisers see every edge
  task automatic wr(input logic [3:0] a, input logic [27:0] d, input int n);
    logic [31:0] w;
    w = {d, a};
    cs_n = 1'b0;
    step(4);
    for (int i = 0; i < n; i++) begin
      sdi = w[31-i];
      step(4);
      sck = 1'b1;
      step(4);
      sck = 1'b0;
    end
    step(4);
    cs_n = 1'b1;
    step(8);
  endtask
  task automatic mode(input logic iq, input logic [1:0] f, input logic [2:0] w);
    wr(gnss_cfg_pkg::ADDR_GAIN_OUT, {iq, 16'h0, f, w, 6'h0}, 32);
  endtask
  task automatic summarize;
    $display("tests %0d failures %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    step(90000);
    n_fail++;
    summarize;
  end

  initial begin
    int i, ns, nt, gap, tsm, den;
    logic [2:0] ci, cv;
    logic [3:0] b;
    step(3);
    rst = 1'b0;
    step(3);
    for (int a = 0; a < 10; a++) chk(cw[a], gnss_cfg_pkg::POR_VALUES[a], "por");
    for (int a = 0; a < 10; a++) begin
      seed = lfsr(seed);
      wr(a[3:0], seed[27:0], 32);
      chk(cw[a], seed[27:0], "write");
      wr(a[3:0], gnss_cfg_pkg::POR_VALUES[a], 32);
    end
    // Unmapped address and a short word leave every register alone
    wr(4'ha, 28'h0, 32);
    wr(4'h3, 28'h0, 31);
    for (int a = 0; a < 10; a++) chk(cw[a], gnss_cfg_pkg::POR_VALUES[a], "refuse");
    $display("test config port done");
    // Slow the sample clock to 48 over 2581 so four lanes fit the stream clock
    wr(gnss_cfg_pkg::ADDR_SAMPLE_DIV, 28'h03061b2, 32);
    den = 4096 - 'h61b + 'h30;
    nt = 0;
    gap = 0;
    tsm = -1;
    for (int c = 0; c < 8 * den; c++) begin
      step(1);
      gap++;
      if (tm === 1'b1) begin
        if (tsm >= 0) chk_n(tsm, 128, 128, "mark period");
        tsm = 0;
      end
      if (tick === 1'b1) begin
        nt++;
        if (nt > 1) chk_n(gap, den / 48, den / 48 + 1, "tick gap");
        gap = 0;
        if (tsm >= 0) tsm++;
      end
    end
    chk_n(nt, 8 * 48 - 1, 8 * 48 + 1, "tick count");
    $display("test divider done");
    for (int m = 0; m < 9; m++) begin
      mode(m < 3 || m > 5, 2'(m % 3), (m < 3) ? 3'h2 : (m < 6) ? 3'h3 : 3'h1);
      for (int k = 0; k < 4; k++) begin
        seed = lfsr(seed);
        ai = seed[2:0];
        aq = seed[5:3];
        for (int w = 0; w < 200 && tick !== 1'b1; w++) step(1);
        step(2);
        ci = code(ai, 2'(m % 3));
        cv = code(aq, 2'(m % 3));
        b = {ci[2], ci[1] & (m < 3), cv[2], cv[1] & (m < 3)};
        if (m < 3 || m > 5) chk({ih, il, qh, ql}, b, "iq pins");
        else chk({ih, il, qh}, ci, "i only pins");
      end
    end
    $display("test pins done");
    mode(1'b1, gnss_cfg_pkg::FMT_SIGN_MAG, 3'h2);
    for (int ls = 0; ls < 4; ls++) begin
      wr(gnss_cfg_pkg::ADDR_SUPPORT, {gnss_cfg_pkg::POR_VALUES[2][27:6], ls[1:0],
        gnss_cfg_pkg::POR_VALUES[2][3:0]}, 32);
      seed = lfsr(seed);
      ai = seed[2:0];
      aq = seed[5:3];
      b = {aq[1], aq[2], ai[1], ai[2]}; // Q magnitude, Q sign, I magnitude, I sign
      run = 1'b1;
      step(2000);
      cap = 1'b1;
      step(3500);
      cap = 1'b0;
      run = 1'b0;
      i = 0;
      ns = 0;
      gap = 0; // Idle run before a group start
      while (i < cq.size() && !(cq[i][1] === 1'b1 && gap >= 16)) begin
        gap = (cq[i] === 2'b00) ? gap + 1 : 0;
        i++;
      end
      while (i + 64 <= cq.size()) begin
        for (int l = 0; l < 4; l++) if (gnss_cfg_pkg::LANE_MASKS[ls][l]) begin
          for (int k = 0; k < 16; k++) chk(cq[i+k], {k == 0, b[l]}, "slice");
          i += 16;
        end
        while (i < cq.size() && cq[i][1] !== 1'b1) begin
          chk(cq[i], 2'b00, "fill");
          i++;
        end
        ns++;
      end
      chk_n(ns, 2, 9, "slice groups");
      cq.delete();
    end
    wr(gnss_cfg_pkg::ADDR_STREAM, 28'h0, 32);
    run = 1'b1;
    step(1000);
    cap = 1'b1;
    wr(gnss_cfg_pkg::ADDR_STREAM, 28'h8000002, 32);
    step(3000);
    run = 1'b0;
    ns = 0;
    foreach (cq[j]) ns += int'(cq[j][1]);
    chk_n(ns, 8, 8, "frame limit");
    $display("test stream done");
    for (int s = 0; s < 8; s++) begin
      pre = 1'b1;
      {sck, sdi, cs_n} = s[2:0];
      step(8);
      chk(cw[0], gnss_cfg_pkg::PRESET_RX_IF[s], "preset 0");
      chk(cw[1], gnss_cfg_pkg::PRESET_GAIN_OUT[s], "preset 1");
      chk(cw[4], gnss_cfg_pkg::PRESET_DIVIDER[s], "preset 4");
      chk(cw[9], gnss_cfg_pkg::PRESET_TEST_MODE_SECOND[s], "preset 9");
      chk(cw[2], gnss_cfg_pkg::POR_VALUES[2], "preset 2");
    end
    pre = 1'b0;
    {sck, sdi, cs_n} = 3'h1;
    step(8);
    chk(cw[9], gnss_cfg_pkg::PRESET_TEST_MODE_SECOND[7], "preset kept");
    $display("test presets done");
    summarize;
  end
endmodule // gnss_sample_serializer_config_bench
`default_nettype wire
